/* rtl/ffo_consts.vh */
// Constants for the flag offset configuration block
`ifndef FFO_CONSTS_VH
`define FFO_CONSTS_VH
`define FFO_DATA_W      36
`define FFO_OFS_W       18
`define FFO_CNT_W       19
`define FFO_DEPTH       19'h40000
`define FFO_ADDR_W      4
`define FFO_A_CTRL      4'h0
`define FFO_A_STATUS    4'h1
`define FFO_A_EMPTY_OFS 4'h2
`define FFO_A_FULL_OFS  4'h3
`define FFO_A_IRQ_STAT  4'h4
`define FFO_A_IRQ_MASK  4'h5
`define FFO_A_COUNT     4'h6
`define FFO_EV_W        3
`define FFO_EV_PAE      0
`define FFO_EV_PAF      1
`define FFO_EV_PROG     2
`define FFO_DEF_1023    18'h003FF
`define FFO_DEF_511     18'h001FF
`define FFO_DEF_255     18'h000FF
`define FFO_DEF_127     18'h0007F
`define FFO_DEF_63      18'h0003F
`define FFO_DEF_31      18'h0001F
`define FFO_DEF_15      18'h0000F
`define FFO_DEF_7       18'h00007
`define FFO_DEF_3       18'h00003
`define FFO_ST_RUN      2'h0
`define FFO_ST_SER      2'h1
`define FFO_SER_LAST    6'h23
`endif

/* rtl/ffo_default_sel.v */
// Default offset decoder driven by the three select pins and large_part
`timescale 1ns/100ps
`include "ffo_consts.vh"
module ffo_default_sel (
  // Selects
  input  wire                    large_part,
  input  wire                    load_sel,
  input  wire                    sel_1,
  input  wire                    sel_0,
  // Result
  output reg  [`FFO_OFS_W-1:0]   default_ofs
);
  always @* begin
    case ({load_sel, sel_1, sel_0})
      3'h2: default_ofs = `FFO_DEF_511;
      3'h1: default_ofs = `FFO_DEF_255;
      3'h0: default_ofs = `FFO_DEF_127;
      3'h3: default_ofs = `FFO_DEF_63;
      3'h4: default_ofs = large_part ? `FFO_DEF_1023 : `FFO_DEF_31;
      3'h6: default_ofs = large_part ? `FFO_DEF_31 : `FFO_DEF_15;
      3'h5: default_ofs = large_part ? `FFO_DEF_15 : `FFO_DEF_7;
      default: default_ofs = large_part ? `FFO_DEF_7 : `FFO_DEF_3;
    endcase
  end
endmodule

/* rtl/ffo_flag_offset.v */
// Flag offset registers, defaults, programming and almost flags
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "ffo_consts.vh"
module ffo_flag_offset (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    srst,
  // Strap and control pins
  input  wire                    offset_load_select,
  input  wire                    default_offset_sel_1,
  input  wire                    default_offset_sel_0,
  input  wire                    large_part,
  // Parallel offset load
  input  wire                    par_write,
  input  wire [`FFO_DATA_W-1:0]  par_data_in,
  // Serial offset load
  input  wire                    ser_enable,
  input  wire                    ser_data_in,
  // Offset read-back
  input  wire                    par_read,
  output reg  [`FFO_DATA_W-1:0]  parallel_data_out,
  output reg                     parallel_data_valid,
  // Word count from the data path
  input  wire [`FFO_CNT_W-1:0]   word_count,
  // Flags
  output reg                     almost_empty_flag_n,
  output reg                     almost_full_flag_n,
  // Register port
  input  wire [`FFO_ADDR_W-1:0]  reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_write,
  input  wire                    reg_read,
  output reg  [31:0]             reg_rdata,
  // Interrupt
  output wire                    irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Offsets and captured mode
  reg  [`FFO_OFS_W-1:0]   empty_ofs;
  reg  [`FFO_OFS_W-1:0]   full_ofs;
  reg                     serial_mode;
  reg                     in_reset;
  reg                     strap_done;

  // Serial shifter and shared word pointer
  reg  [`FFO_OFS_W*2-1:0] ser_shift;
  reg  [5:0]              ser_count;
  reg                     read_sel;

  // Interrupt state and register read data
  reg  [`FFO_EV_W-1:0]    irq_stat;
  reg  [`FFO_EV_W-1:0]    irq_mask;
  reg  [`FFO_EV_W-1:0]    next_irq_stat;
  reg  [31:0]             next_rdata;
  wire [31:0]             status_word;

  // Decoded strobes
  reg                     soft_write;
  reg                     soft_target;
  wire                    wr_empty_sel;
  wire                    wr_full_sel;
  wire                    wr_stat_sel;
  wire                    wr_mask_sel;
  wire                    ser_step;
  wire                    ser_last;
  wire                    ser_done;
  wire                    par_step;
  wire                    read_take;
  wire                    prog_evt;

  // Flag comparison and event lanes
  wire [`FFO_OFS_W-1:0]   default_ofs;
  wire [`FFO_CNT_W-1:0]   full_limit;
  wire                    pae_now;
  wire                    paf_now;
  reg                     prev_pae;
  reg                     prev_paf;
  wire [`FFO_OFS_W-1:0]   read_ofs;
  wire [`FFO_EV_W-1:0]    ev_now;
  wire [`FFO_EV_W-1:0]    ev_prev;
  wire [`FFO_EV_W-1:0]    ev_qual;
  wire [`FFO_EV_W-1:0]    ev_set;
  genvar                  lane;

  ////////////////////////////////////////////////////////////////////////////
  // Register address match, shared by the write decoders below; read decode uses a case
  function addr_is;
    input [`FFO_ADDR_W-1:0] addr;
    input [`FFO_ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Value at or below a limit; used for both flag compares, the full one with the count as the limit
  function at_or_below;
    input [`FFO_CNT_W-1:0] value;
    input [`FFO_CNT_W-1:0] limit;
    begin
      at_or_below = (value <= limit);
    end
  endfunction

  // Rising edge of one event lane, gated by its qualifier
  function lane_rise;
    input now;
    input prev;
    input qual;
    begin
      lane_rise = now && !prev && qual;
    end
  endfunction

  // Offset widened to a register word; upper bits read as zero
  function [31:0] ofs_word;
    input [`FFO_OFS_W-1:0] ofs;
    begin
      ofs_word = {14'h0000, ofs};
    end
  endfunction

  ffo_default_sel u_def (
    .large_part  (large_part),
    .load_sel    (offset_load_select),
    .sel_1       (default_offset_sel_1),
    .sel_0       (default_offset_sel_0),
    .default_ofs (default_ofs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag comparison; flags lag the count by one cycle
  assign full_limit = `FFO_DEPTH - {1'b0, full_ofs};
  assign pae_now    = at_or_below(word_count, {1'b0, empty_ofs});
  assign paf_now    = at_or_below(full_limit, word_count);

  ////////////////////////////////////////////////////////////////////////////
  // Load strobes; pin loads only count in the mode chosen at reset
  assign ser_step  = serial_mode && ser_enable;
  assign ser_last  = (ser_count == `FFO_SER_LAST);
  assign ser_done  = ser_step && ser_last;
  assign par_step  = !serial_mode && par_write;
  assign read_take = par_read && !in_reset;
  assign prog_evt  = !in_reset &&
                     (ser_done || par_step || soft_write);

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  // Decoded once here so every consumer sees the same strobe
  assign wr_empty_sel = reg_write && addr_is(reg_addr, `FFO_A_EMPTY_OFS);
  assign wr_full_sel  = reg_write && addr_is(reg_addr, `FFO_A_FULL_OFS);
  assign wr_stat_sel  = reg_write && addr_is(reg_addr, `FFO_A_IRQ_STAT);
  assign wr_mask_sel  = reg_write && addr_is(reg_addr, `FFO_A_IRQ_MASK);

  // Offset writes held off in the first cycle after reset
  always @* begin
    soft_write  = !in_reset && (wr_empty_sel || wr_full_sel);
    soft_target = wr_full_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture; straps must be steady on the last reset edge
  always @(posedge sys_clk) begin
    if (srst) begin
      in_reset    <= 1'b1;
      strap_done  <= 1'b0;
      serial_mode <= offset_load_select;
    end else begin
      in_reset   <= 1'b0;
      strap_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter; empty offset bits first, then full, LSB first
  // A register offset write in the same cycle drops the serial bit
  always @(posedge sys_clk) begin
    if (srst) begin
      ser_shift <= {(`FFO_OFS_W*2){1'b0}};
      ser_count <= 6'h00;
    end else if (!in_reset && !soft_write && ser_step) begin
      ser_shift <= {ser_data_in, ser_shift[`FFO_OFS_W*2-1:1]};
      if (ser_last)
        ser_count <= 6'h00;
      else
        ser_count <= ser_count + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word pointer shared by parallel loads and read-back
  // Moves on reads too, except in a cycle with a register offset write or a serial step, so a pair comes out in turn
  always @(posedge sys_clk) begin
    if (srst) begin
      read_sel <= 1'b0;
    end else if (!in_reset && !soft_write && !ser_step) begin
      if (par_step || par_read)
        read_sel <= ~read_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset registers; a register write beats a pin load in one cycle
  // Limitation: values above depth minus one are not refused here
  always @(posedge sys_clk) begin
    if (srst) begin
      empty_ofs <= default_ofs;
      full_ofs  <= default_ofs;
    end else if (!in_reset) begin
      if (soft_write) begin
        if (soft_target)
          full_ofs <= reg_wdata[`FFO_OFS_W-1:0];
        else
          empty_ofs <= reg_wdata[`FFO_OFS_W-1:0];
      end else if (ser_done) begin
        empty_ofs <= ser_shift[`FFO_OFS_W:1];
        full_ofs  <= {ser_data_in,
                      ser_shift[`FFO_OFS_W*2-1:`FFO_OFS_W+1]};
      end else if (par_step) begin
        // Two parallel words, empty then full
        if (read_sel)
          full_ofs <= par_data_in[`FFO_OFS_W-1:0];
        else
          empty_ofs <= par_data_in[`FFO_OFS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back only in parallel form, either mode
  assign read_ofs = read_sel ? full_ofs : empty_ofs;

  always @(posedge sys_clk) begin
    if (srst) begin
      parallel_data_out   <= {`FFO_DATA_W{1'b0}};
      parallel_data_valid <= 1'b0;
    end else begin
      parallel_data_valid <= read_take;
      if (read_take)
        parallel_data_out <= {{(`FFO_DATA_W-`FFO_OFS_W){1'b0}}, read_ofs};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, registered; high through reset
  // History cleared in reset; strap_done keeps a false event away
  always @(posedge sys_clk) begin
    if (srst) begin
      almost_empty_flag_n <= 1'b1;
      almost_full_flag_n  <= 1'b1;
      prev_pae            <= 1'b0;
      prev_paf            <= 1'b0;
    end else begin
      almost_empty_flag_n <= ~pae_now;
      almost_full_flag_n  <= ~paf_now;
      prev_pae            <= pae_now;
      prev_paf            <= paf_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event lanes; flag bits need a rising edge, program bit is a pulse
  // Program lane has no history, so each pulse sets the bit
  assign ev_now[`FFO_EV_PAE]   = pae_now;
  assign ev_now[`FFO_EV_PAF]   = paf_now;
  assign ev_now[`FFO_EV_PROG]  = prog_evt;
  assign ev_prev[`FFO_EV_PAE]  = prev_pae;
  assign ev_prev[`FFO_EV_PAF]  = prev_paf;
  assign ev_prev[`FFO_EV_PROG] = 1'b0;
  assign ev_qual[`FFO_EV_PAE]  = strap_done;
  assign ev_qual[`FFO_EV_PAF]  = strap_done;
  assign ev_qual[`FFO_EV_PROG] = 1'b1;

  generate
    for (lane = 0; lane < `FFO_EV_W; lane = lane + 1) begin : g_event
      assign ev_set[lane] = lane_rise(ev_now[lane], ev_prev[lane],
                                      ev_qual[lane]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts; set wins over write-one clear
  always @* begin
    next_irq_stat = irq_stat;
    if (wr_stat_sel)
      next_irq_stat = irq_stat & ~reg_wdata[`FFO_EV_W-1:0];
    next_irq_stat = next_irq_stat | ev_set;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      irq_stat <= {`FFO_EV_W{1'b0}};
      irq_mask <= {`FFO_EV_W{1'b0}};
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_mask_sel)
        irq_mask <= reg_wdata[`FFO_EV_W-1:0];
    end
  end

  // Level output; stays high until software clears or masks the bit
  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Register read data; zero outside the answer cycle
  // Unmapped addresses read zero and ignore writes
  assign status_word = {28'h0000000, read_sel, ~almost_full_flag_n,
                        ~almost_empty_flag_n, serial_mode};

  always @* begin
    next_rdata = 32'h00000000;
    if (reg_read) begin
      case (reg_addr)
        `FFO_A_STATUS:    next_rdata = status_word;
        `FFO_A_EMPTY_OFS: next_rdata = ofs_word(empty_ofs);
        `FFO_A_FULL_OFS:  next_rdata = ofs_word(full_ofs);
        `FFO_A_IRQ_STAT:  next_rdata = {29'h00000000, irq_stat};
        `FFO_A_IRQ_MASK:  next_rdata = {29'h00000000, irq_mask};
        `FFO_A_COUNT:     next_rdata = {13'h0000, word_count};
        default:          next_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (srst)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= next_rdata;
  end
endmodule

/* dv/ffo_host_ser.sv */
// Host model shifting one offset pair in on the serial pins
`timescale 1ns/100ps
module ffo_host_ser (
  // Clock and request
  input  wire        sys_clk,
  input  wire        start,
  input  wire [35:0] word,
  // Serial pins and status
  output reg         ser_enable = 1'b0,
  output reg         ser_data_in = 1'b0,
  output reg         busy = 1'b0
);
  reg [5:0]  left = 6'h0;
  reg [35:0] sh;
  // Random gaps between bits; idle data toggles so a stale bit cannot pass
  always @(posedge sys_clk) begin
    ser_enable <= 1'b0;
    ser_data_in <= ~ser_data_in;
    busy <= left != 6'h0;
    if (start) begin
      sh <= word;
      left <= 6'h24;
      busy <= 1'b1;
    end else if (left != 6'h0 && $urandom_range(1, 0) == 1) begin
      ser_enable <= 1'b1;
      ser_data_in <= sh[0];
      sh <= sh >> 1;
      left <= left - 6'h1;
    end
  end
endmodule

/* dv/ffo_flag_offset_chk.sv */
// Port checker for the flag offset block
`timescale 1ns/100ps
`include "ffo_consts.vh"
module ffo_flag_offset_chk (
  // Watched ports
  input wire                  sys_clk,
  input wire                  srst,
  input wire                  par_read,
  input wire                  parallel_data_valid,
  input wire [`FFO_CNT_W-1:0] word_count,
  input wire                  almost_empty_flag_n,
  input wire                  almost_full_flag_n,
  input wire                  reg_read,
  input wire [31:0]           reg_rdata,
  input wire                  irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Count limits hold for any legal offset
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_read_answer: assert property (par_read && !$past(srst) |=>
    parallel_data_valid) else $error("offset read not answered");
  a_valid_cause: assert property (parallel_data_valid |->
    $past(par_read)) else $error("valid without read");
  a_reset_flags: assert property ($fell(srst) |->
    almost_empty_flag_n && almost_full_flag_n && !irq)
    else $error("flags not idle at reset");
  a_empty_low: assert property ($past(word_count) == 19'h0 &&
    !$past(srst) |-> !almost_empty_flag_n) else $error("empty not low");
  a_empty_high: assert property ($past(word_count) == `FFO_DEPTH &&
    !$past(srst) |-> almost_empty_flag_n) else $error("empty not high");
  a_full_low: assert property ($past(word_count) == `FFO_DEPTH &&
    !$past(srst) |-> !almost_full_flag_n) else $error("full not low");
  a_full_high: assert property ($past(word_count) == 19'h0 &&
    !$past(srst) |-> almost_full_flag_n) else $error("full not high");
  c_par_read: cover property (par_read ##1 parallel_data_valid);
  c_irq_high: cover property (irq);
  c_full_flag: cover property ($fell(almost_full_flag_n));
endmodule
bind ffo_flag_offset ffo_flag_offset_chk ffo_flag_offset_chk_i (.sys_clk,
  .srst, .par_read, .parallel_data_valid, .word_count, .almost_empty_flag_n,
  .almost_full_flag_n, .reg_read, .reg_rdata, .irq);

/* dv/ffo_flag_offset_tb.sv */
// Self-checking bench for the flag offset block
`timescale 1ns/100ps
`include "ffo_consts.vh"
module ffo_flag_offset_tb;
  reg         sys_clk = 1'b0, srst = 1'b1, start = 1'b0, par_write = 1'b0;
  reg         offset_load_select = 1'b0, default_offset_sel_1 = 1'b0;
  reg         default_offset_sel_0 = 1'b0, large_part = 1'b0;
  reg         par_read = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  reg  [35:0] par_data_in = 36'h0;
  reg  [18:0] word_count = 19'h0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg  [17:0] n = 18'h0, m = 18'h0;
  wire        ser_enable, ser_data_in, busy, parallel_data_valid, irq;
  wire        almost_empty_flag_n, almost_full_flag_n;
  wire [35:0] parallel_data_out;
  wire [31:0] reg_rdata;
  integer     num_errors = 0, check_count = 0, cyc = 0, i, k;
  always #20 sys_clk = ~sys_clk;
  ffo_flag_offset ffo_flag_offset_i (.sys_clk, .srst, .offset_load_select,
    .default_offset_sel_1, .default_offset_sel_0, .large_part, .par_write,
    .par_data_in, .ser_enable, .ser_data_in, .par_read, .parallel_data_out,
    .parallel_data_valid, .word_count, .almost_empty_flag_n,
    .almost_full_flag_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .irq);
  ffo_host_ser ffo_host_ser_i (.sys_clk, .start, .word({m, n}), .ser_enable,
    .ser_data_in, .busy);
  task chk(input [35:0] seen, input [35:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task rc(input [3:0] a, input [31:0] e);
    begin
      @(posedge sys_clk) reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk) reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk) reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk) reg_write <= 1'b0;
      #1;
    end
  endtask
  // One pin access: write a word, or read one back and compare
  task pin(input w, input [17:0] e);
    begin
      @(posedge sys_clk) par_write <= w;
      par_read <= !w;
      par_data_in <= {18'h0, e};
      @(posedge sys_clk) par_write <= 1'b0;
      par_read <= 1'b0;
      #1 if (!w) chk(parallel_data_out[17:0], e);
      if (!w) chk(parallel_data_out[35:18], 18'h0);
      if (!w) chk(parallel_data_valid, 1'b1);
    end
  endtask
  task cnt(input [18:0] v);
    begin
      @(posedge sys_clk) word_count <= v;
      repeat (2) @(posedge sys_clk);
      #1;
    end
  endtask
  task rst(input [3:0] c);
    begin
      @(posedge sys_clk) srst <= 1'b1;
      {large_part, offset_load_select, default_offset_sel_1,
        default_offset_sel_0} <= c;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  function [17:0] dflt(input [3:0] c);
    case (c[2:0])
      3'h0: dflt = 18'h0007F;
      3'h1: dflt = 18'h000FF;
      3'h2: dflt = 18'h001FF;
      3'h3: dflt = 18'h0003F;
      3'h4: dflt = c[3] ? 18'h003FF : 18'h0001F;
      3'h5: dflt = c[3] ? 18'h0000F : 18'h00007;
      3'h6: dflt = c[3] ? 18'h0001F : 18'h0000F;
      default: dflt = c[3] ? 18'h00007 : 18'h00003;
    endcase
  endfunction
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  initial begin
    k = $urandom(5);
    for (i = 0; i < 16; i = i + 1) begin
      rst(i[3:0]);
      rc(4'h2, dflt(i[3:0]));
      rc(4'h3, dflt(i[3:0]));
    end
    $display("test defaults done");
    k = $urandom;
    n = k[17:0];
    m = 18'h3FFFF;
    rst(4'h0);
    pin(1'b1, n);
    pin(1'b1, m);
    pin(1'b0, n);
    pin(1'b0, m);
    $display("test parallel done");
    m = k[31:14];
    rst(4'hC);
    pin(1'b1, 18'h00005);
    rc(4'h2, 32'h003FF);
    @(posedge sys_clk) start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    #1 for (i = 0; i < 300 && busy === 1'b1; i = i + 1) @(posedge sys_clk);
    @(posedge sys_clk);
    pin(1'b0, n);
    rc(4'h3, {14'h0, m});
    wr(4'h5, 32'h0);
    cnt({1'b0, n} + 19'h1);
    chk(almost_empty_flag_n, 1'b1);
    cnt({1'b0, n});
    chk(almost_empty_flag_n, 1'b0);
    chk(irq, 1'b0);
    wr(4'h5, 32'h1);
    chk(irq, 1'b1);
    wr(4'h4, 32'h7);
    chk(irq, 1'b0);
    cnt(`FFO_DEPTH - {1'b0, m} - 19'h1);
    chk(almost_full_flag_n, 1'b1);
    cnt(`FFO_DEPTH - {1'b0, m});
    chk(almost_full_flag_n, 1'b0);
    cnt(`FFO_DEPTH);
    wr(4'h3, 32'h0);
    rc(4'h3, 32'h0);
    rc(4'h4, 32'h6);
    rc(4'h1, 32'hD);
    rc(4'h6, 32'h40000);
    rc(4'h9, 32'h0);
    $display("test serial and flags done");
    wrap_up;
  end
endmodule
